/* sim/fpg_gpio_monitor.sv */
module fpg_gpio_monitor
  import fpg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [fpg_addr_w-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic halted,
  input wire logic wake,
  input wire logic [7:0] pa_in,
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pa_pu,
  input wire logic [5:0] pd_oe,
  input wire logic [5:0] pd_pu
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_dir_to_oe: assert property (wr && addr == fpg_off_a_dir
    |-> ##2 pa_oe == ~$past(wdata, 2)) else $error("port a enable wrong");
  a_data_to_out: assert property (wr && addr == fpg_off_a_data
    |-> ##2 pa_out == $past(wdata, 2)) else $error("port a drive wrong");
  // A write one edge earlier has not reached the pin outputs yet
  a_read_mix: assert property (rd && addr == fpg_off_a_data && !$past(wr)
    |=> rdata == (($past(pa_in) & ~$past(pa_oe)) | ($past(pa_out) & $past(pa_oe))))
    else $error("port a read wrong");
  a_unmapped_zero: assert property (rd && addr > fpg_off_d_dir
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_d_upper_zero: assert property (rd && addr >= fpg_off_d_pull
    |=> rdata[7:6] == 2'h0) else $error("port d upper bits set");
  a_pull_input_only: assert property ((pa_pu & pa_oe) == 8'h00
    && (pd_pu & pd_oe) == 6'h00) else $error("pull-up on driven pin");
  a_wake_pulse: assert property (wake |=> !wake) else $error("wake longer than one cycle");
  a_wake_running: assert property (!halted [*3] |-> !wake)
    else $error("wake while running");
  c_wake: cover property (wake);
  c_read_a: cover property (rd && addr == fpg_off_a_data);
  c_dir_a: cover property (wr && addr == fpg_off_a_dir);
endmodule : fpg_gpio_monitor

/* sim/fpg_pins.sv */
module fpg_pins #(parameter int w = 8)
(
  input wire logic clk,
  input wire logic [w-1:0] out,
  input wire logic [w-1:0] oe,
  input wire logic [w-1:0] pu,
  input wire logic [w-1:0] sw_en,
  input wire logic [w-1:0] sw_val,
  output logic [w-1:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt = 1'b0;
  // A pin nobody drives or pulls up wanders, so a read of it is never trusted
  always @(posedge clk) flt <= ~flt;
  assign lvl = (oe & out) | (~oe & sw_en & sw_val) | (~oe & ~sw_en & (pu | {w{flt}}));
endmodule : fpg_pins

/* sim/testbench.sv */
module testbench
  import fpg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr = 0, rd = 0, halted = 0, wake, ce = 1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, sw_en = 8'hff, sw_val = 8'ha5, rdata;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pu, pb_in, pb_out, pb_oe, pb_pu;
  logic [7:0] pc_in, pc_out, pc_oe, pc_pu;
  logic [5:0] pd_in, pd_out, pd_oe, pd_pu;
  int bad_count = 0, samples_checked = 0;
  fpg_gpio fpg_gpio_inst (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .rdata(rdata), .halted(halted), .wake(wake), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .pb_pu(pb_pu), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .pc_pu(pc_pu), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pd_pu(pd_pu));
  fpg_pins pa_pins (.clk(clk), .out(pa_out), .oe(pa_oe), .pu(pa_pu), .sw_en(sw_en),
    .sw_val(sw_val), .lvl(pa_in));
  fpg_pins pb_pins (.clk(clk), .out(pb_out), .oe(pb_oe), .pu(pb_pu), .sw_en(sw_en),
    .sw_val(sw_val), .lvl(pb_in));
  fpg_pins pc_pins (.clk(clk), .out(pc_out), .oe(pc_oe), .pu(pc_pu), .sw_en(sw_en),
    .sw_val(sw_val), .lvl(pc_in));
  fpg_pins #(6) pd_pins (.clk(clk), .out(pd_out), .oe(pd_oe), .pu(pd_pu), .sw_en(sw_en[5:0]),
    .sw_val(sw_val[5:0]), .lvl(pd_in));
  initial forever #50 clk = ~clk;
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e)
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    bad_count += (g !== e);
  endtask : chk
  // Each bus task ends one idle cycle later so strobes never toggle twice in a step
  task automatic put(logic [3:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
    @(negedge clk);
  endtask : put
  task automatic get(logic [3:0] a, logic [7:0] e, string n);
    addr = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    chk(n, e, rdata);
    @(negedge clk);
  endtask : get
  task automatic watch(logic [7:0] e, string n);
    logic [7:0] seen = 8'h00;
    repeat (6) @(negedge clk) seen |= {7'h0, wake};
    chk(n, e, seen);
  endtask : watch
  task automatic t_reset();
    logic [7:0] e [16] = '{8'h00, 8'h00, 8'ha5, 8'hff, 8'h00, 8'ha5, 8'hff, 8'h00, 8'ha5,
      8'hff, 8'h00, 8'h25, 8'h3f, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 16; i++)
      get(4'(i), e[i], "reset read");
    chk("a out", 8'hff, pa_out);
    chk("c oe", 8'h00, pc_oe);
    chk("d out", 8'h3f, {2'h0, pd_out});
    $display("done: reset");
  endtask : t_reset
  task automatic t_output();
    put(fpg_off_a_dir, 8'h0f);
    put(fpg_off_a_data, 8'h3c);
    chk("a oe", 8'hf0, pa_oe);
    chk("a out", 8'h3c, pa_out);
    get(fpg_off_a_data, 8'h35, "a mixed");
    put(fpg_off_a_dir, 8'h00);
    chk("a oe all", 8'hff, pa_oe);
    get(fpg_off_a_data, 8'h3c, "a latch");
    put(fpg_off_a_dir, 8'hff);
    sw_val = 8'h5a;
    get(fpg_off_a_data, 8'h5a, "a live");
    $display("done: output");
  endtask : t_output
  task automatic t_pull();
    sw_en = 8'h00;
    put(fpg_off_b_pull, 8'hff);
    put(fpg_off_b_dir, 8'h0f);
    chk("b pull", 8'h0f, pb_pu);
    chk("b out", 8'hff, pb_out);
    get(fpg_off_b_data, 8'hff, "b pulled");
    put(fpg_off_b_pull, 8'h00);
    chk("b pull off", 8'h00, pb_pu);
    sw_en = 8'hff;
    $display("done: pull");
  endtask : t_pull
  task automatic t_port_d();
    put(fpg_off_d_dir, 8'h00);
    put(fpg_off_d_data, 8'hff);
    chk("d oe", 8'h3f, {2'h0, pd_oe});
    get(fpg_off_d_data, 8'h3f, "d data");
    get(fpg_off_d_dir, 8'h00, "d dir");
    put(4'he, 8'hff);
    get(4'he, 8'h00, "unmapped");
    // With the clock enable low nothing may change
    ce = 1'b0;
    put(fpg_off_d_data, 8'h00);
    ce = 1'b1;
    get(fpg_off_d_data, 8'h3f, "d frozen");
    put(fpg_off_c_pull, 8'hff);
    put(fpg_off_c_dir, 8'h00);
    put(fpg_off_c_data, 8'h96);
    chk("c out", 8'h96, pc_out);
    chk("c oe", 8'hff, pc_oe);
    chk("c pull", 8'h00, pc_pu);
    chk("d pull", 8'h00, {2'h0, pd_pu});
    $display("done: port d");
  endtask : t_port_d
  task automatic t_wake();
    put(fpg_off_a_wake, 8'h01);
    sw_val = 8'hff;
    halted = 1'b1;
    @(negedge clk) sw_val = 8'hfd;
    watch(8'h00, "disarmed wake");
    sw_val = 8'hfc;
    watch(8'h01, "armed wake");
    sw_val = 8'hff;
    halted = 1'b0;
    @(negedge clk) sw_val = 8'hfe;
    watch(8'h00, "running wake");
    $display("done: wake");
  endtask : t_wake
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_output();
    t_pull();
    t_port_d();
    t_wake();
    report_and_stop();
  end
endmodule : testbench
bind fpg_gpio fpg_gpio_monitor fpg_gpio_monitor_inst (.clk(clk), .rst(rst), .addr(addr),
  .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .halted(halted), .wake(wake),
  .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pa_pu(pa_pu), .pd_oe(pd_oe), .pd_pu(pd_pu));

/* src/fpg_gpio.sv */
module fpg_gpio
  import fpg_pkg::*;
#(
  parameter int unsigned data_w = fpg_data_w
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [fpg_addr_w-1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic halted,
  output logic wake,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pu,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pu,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  output logic [7:0] pc_pu,
  input wire logic [5:0] pd_in,
  output logic [5:0] pd_out,
  output logic [5:0] pd_oe,
  output logic [5:0] pd_pu
);
  if (data_w != fpg_data_w)
    $error("fpg_gpio serves only 8-bit data");

  logic [7:0] port_a_wake_enable;
  logic [7:0] port_a_pullup_enable;
  logic [7:0] port_a_data;
  logic [7:0] port_a_direction;
  logic [7:0] port_b_pullup_enable;
  logic [7:0] port_b_data;
  logic [7:0] port_b_direction;
  logic [7:0] port_c_pullup_enable;
  logic [7:0] port_c_data;
  logic [7:0] port_c_direction;
  logic [7:0] port_d_pullup_enable;
  logic [7:0] port_d_data;
  logic [7:0] port_d_direction;
  logic [7:0] pa_prev;

  fpg_pin_if #(.width(8)) if_a ();
  fpg_pin_if #(.width(8)) if_b ();
  fpg_pin_if #(.width(8)) if_c ();
  fpg_pin_if #(.width(8)) if_d ();

  assign if_a.latch = port_a_data;
  assign if_a.dir = port_a_direction;
  assign if_a.pull = port_a_pullup_enable;
  assign if_a.pin_in = pa_in;
  assign if_b.latch = port_b_data;
  assign if_b.dir = port_b_direction;
  assign if_b.pull = port_b_pullup_enable;
  assign if_b.pin_in = pb_in;
  assign if_c.latch = port_c_data;
  assign if_c.dir = port_c_direction;
  assign if_c.pull = port_c_pullup_enable;
  assign if_c.pin_in = pc_in;
  assign if_d.latch = port_d_data;
  assign if_d.dir = port_d_direction;
  assign if_d.pull = port_d_pullup_enable;
  assign if_d.pin_in = {2'h0, pd_in};

  fpg_pin_mux u_mux_a (.p(if_a));
  fpg_pin_mux u_mux_b (.p(if_b));
  fpg_pin_mux u_mux_c (.p(if_c));
  fpg_pin_mux u_mux_d (.p(if_d));

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  wire we = ce & wr;
  wire [7:0] wd_d = wdata & fpg_d_mask;

  // Gaps in the map read as zero
  logic [7:0] next_rdata;
  always_comb
  begin
    case (addr)
      fpg_off_a_wake: next_rdata = port_a_wake_enable;
      fpg_off_a_pull: next_rdata = port_a_pullup_enable;
      fpg_off_a_data: next_rdata = if_a.rd_val;
      fpg_off_a_dir: next_rdata = port_a_direction;
      fpg_off_b_pull: next_rdata = port_b_pullup_enable;
      fpg_off_b_data: next_rdata = if_b.rd_val;
      fpg_off_b_dir: next_rdata = port_b_direction;
      fpg_off_c_pull: next_rdata = port_c_pullup_enable;
      fpg_off_c_data: next_rdata = if_c.rd_val;
      fpg_off_c_dir: next_rdata = port_c_direction;
      fpg_off_d_pull: next_rdata = port_d_pullup_enable & fpg_d_mask;
      fpg_off_d_data: next_rdata = if_d.rd_val & fpg_d_mask;
      fpg_off_d_dir: next_rdata = port_d_direction & fpg_d_mask;
      default: next_rdata = fpg_rst_zero;
    endcase
  end

  // Falling edge on an armed port A read value (pin, or latch for outputs), only counted while halted
  wire [7:0] pa_fall = pa_prev & ~if_a.rd_val & port_a_wake_enable;
  wire next_wake = halted & (|pa_fall);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      port_a_wake_enable <= fpg_rst_zero;
      port_a_pullup_enable <= fpg_rst_zero;
      port_a_data <= fpg_rst_ones;
      port_a_direction <= fpg_rst_ones;
      port_b_pullup_enable <= fpg_rst_zero;
      port_b_data <= fpg_rst_ones;
      port_b_direction <= fpg_rst_ones;
      port_c_pullup_enable <= fpg_rst_zero;
      port_c_data <= fpg_rst_ones;
      port_c_direction <= fpg_rst_ones;
      port_d_pullup_enable <= fpg_rst_zero;
      port_d_data <= fpg_d_mask;
      port_d_direction <= fpg_d_mask;
    end
    else if (we)
    begin
      // Each register holds until its own address is written again
      if (hit(addr, fpg_off_a_wake)) port_a_wake_enable <= wdata;
      if (hit(addr, fpg_off_a_pull)) port_a_pullup_enable <= wdata;
      if (hit(addr, fpg_off_a_data)) port_a_data <= wdata;
      if (hit(addr, fpg_off_a_dir)) port_a_direction <= wdata;
      if (hit(addr, fpg_off_b_pull)) port_b_pullup_enable <= wdata;
      if (hit(addr, fpg_off_b_data)) port_b_data <= wdata;
      if (hit(addr, fpg_off_b_dir)) port_b_direction <= wdata;
      if (hit(addr, fpg_off_c_pull)) port_c_pullup_enable <= wdata;
      if (hit(addr, fpg_off_c_data)) port_c_data <= wdata;
      if (hit(addr, fpg_off_c_dir)) port_c_direction <= wdata;
      if (hit(addr, fpg_off_d_pull)) port_d_pullup_enable <= wd_d;
      if (hit(addr, fpg_off_d_data)) port_d_data <= wd_d;
      if (hit(addr, fpg_off_d_dir)) port_d_direction <= wd_d;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= fpg_rst_zero;
      wake <= 1'b0;
      pa_prev <= fpg_rst_zero;
      pa_out <= fpg_rst_ones;
      pa_oe <= fpg_rst_zero;
      pa_pu <= fpg_rst_zero;
      pb_out <= fpg_rst_ones;
      pb_oe <= fpg_rst_zero;
      pb_pu <= fpg_rst_zero;
      pc_out <= fpg_rst_ones;
      pc_oe <= fpg_rst_zero;
      pc_pu <= fpg_rst_zero;
      pd_out <= fpg_d_mask[5:0];
      pd_oe <= fpg_rst_zero[5:0];
      pd_pu <= fpg_rst_zero[5:0];
    end
    else if (ce)
    begin
      if (rd)
        rdata <= next_rdata;
      wake <= next_wake;
      pa_prev <= if_a.rd_val;
      pa_out <= port_a_data;
      pa_oe <= if_a.oe;
      pa_pu <= if_a.pu_on;
      pb_out <= port_b_data;
      pb_oe <= if_b.oe;
      pb_pu <= if_b.pu_on;
      pc_out <= port_c_data;
      pc_oe <= if_c.oe;
      pc_pu <= if_c.pu_on;
      pd_out <= port_d_data[5:0];
      pd_oe <= if_d.oe[5:0];
      pd_pu <= if_d.pu_on[5:0];
    end
  end
endmodule : fpg_gpio

/* src/fpg_pin_if.sv */
interface fpg_pin_if #(parameter int unsigned width = 8);
  logic [width-1:0] latch;
  logic [width-1:0] dir;
  logic [width-1:0] pull;
  logic [width-1:0] pin_in;
  logic [width-1:0] rd_val;
  logic [width-1:0] oe;
  logic [width-1:0] pu_on;
  modport ctrl (output latch, output dir, output pull, output pin_in,
    input rd_val, input oe, input pu_on);
  modport pin (input latch, input dir, input pull, input pin_in,
    output rd_val, output oe, output pu_on);
endinterface : fpg_pin_if

/* src/fpg_pin_mux.sv */
module fpg_pin_mux
  import fpg_pkg::*;
(
  fpg_pin_if.pin p
);
  assign p.oe = ~p.dir;
  assign p.pu_on = p.pull & p.dir;
  // Outputs read back the latch so read-modify-write is safe on loaded pins
  assign p.rd_val = (p.dir & p.pin_in) | (~p.dir & p.latch);
endmodule : fpg_pin_mux

/* src/fpg_pkg.sv */
// What this block does
// - Direction bit one makes the pin an input readable by software.
// - Direction bit zero drives the pin push-pull from its output latch bit.
// - Pull-high bit one enables the weak pull-up, zero disables it.
// - An enabled pull-up connects only while the pin is an input.
// - Each port A wake enable bit arms or disarms wake-up for its pin.
// - While halted, a falling edge on an armed port A pin wakes the processor.
// - Written port data stays in the output latch until rewritten.
// - Port inputs are not latched; a read returns pins sampled during the read.
// - Reading an output pin returns its latch, not the pin level.
// - Each pin has its own direction bit at the same bit position.
// - Direction may change at any time; the pin enables follow one clock after the write.
package fpg_pkg;
  localparam int unsigned fpg_data_w = 8;
  localparam int unsigned fpg_addr_w = 4;
  localparam int unsigned fpg_port_d_w = 6;
  localparam logic [3:0] fpg_off_a_wake = 4'h0;
  localparam logic [3:0] fpg_off_a_pull = 4'h1;
  localparam logic [3:0] fpg_off_a_data = 4'h2;
  localparam logic [3:0] fpg_off_a_dir = 4'h3;
  localparam logic [3:0] fpg_off_b_pull = 4'h4;
  localparam logic [3:0] fpg_off_b_data = 4'h5;
  localparam logic [3:0] fpg_off_b_dir = 4'h6;
  localparam logic [3:0] fpg_off_c_pull = 4'h7;
  localparam logic [3:0] fpg_off_c_data = 4'h8;
  localparam logic [3:0] fpg_off_c_dir = 4'h9;
  localparam logic [3:0] fpg_off_d_pull = 4'ha;
  localparam logic [3:0] fpg_off_d_data = 4'hb;
  localparam logic [3:0] fpg_off_d_dir = 4'hc;
  localparam logic [7:0] fpg_rst_ones = 8'hff;
  localparam logic [7:0] fpg_rst_zero = 8'h00;
  localparam logic [7:0] fpg_d_mask = 8'h3f;
endpackage : fpg_pkg
